// [acp_addr_ptr.sv]
`timescale 1ns/100ps
module acp_addr_ptr (
    input  wire logic clk_in,
    input  wire logic reset_in,
    acp_ptr_if.ptr    pif
);
    logic [7:0] next_book;
    logic [7:0] next_page;
    logic [7:0] next_addr;
    logic [7:0] book;
    logic [7:0] page;
    logic [7:0] addr;

    always_comb begin
        next_book = book;
        next_page = page;
        next_addr = addr;
        if (pif.load) begin
            next_book = pif.ld_book;
            next_page = pif.ld_page;
            next_addr = pif.ld_addr;
        end else if (pif.step) begin
            if (addr != acp_pkg::PAGE_LAST) begin
                next_addr = addr + 8'h01;
            // (R10) Advance to next page
            end else if (book != acp_pkg::BANK_BOOK && !pif.wrap_dis) begin
                next_page = page + 8'h01;
                next_addr = acp_pkg::NEXT_START;
            // (R11) Wrap within page
            end else begin
                next_addr = acp_pkg::SAME_START;
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            book <= 8'h00;
            page <= 8'h00;
            addr <= 8'h00;
        end else if (pif.ce) begin
            book <= next_book;
            page <= next_page;
            addr <= next_addr;
        end
    end

    assign pif.book = book;
    assign pif.page = page;
    assign pif.addr = addr;
endmodule

// [acp_field_decode.sv]
`timescale 1ns/100ps
module acp_field_decode (
    acp_cfg_if.dec cif
);
    logic [2:0] fsw;
    logic [3:0] rto;
    logic [3:0] fsm;

    always_comb begin
        fsw = cif.stage[acp_pkg::FSW_LSB +: 3];
        rto = cif.rate[acp_pkg::RATIO_LSB +: 4];
        fsm = cif.rate[acp_pkg::RATE_LSB +: 4];
        cif.freq_ok  = 1'b1;
        cif.ratio_ok = 1'b1;
        cif.rate_ok  = 1'b1;
        cif.rate_auto = 1'b0;
        // (R1) Switching rate codes
        unique case (fsw)
            3'h0: cif.freq_khz = acp_pkg::FSW_768;
            3'h1: cif.freq_khz = acp_pkg::FSW_384;
            3'h3: cif.freq_khz = acp_pkg::FSW_480;
            3'h4: cif.freq_khz = acp_pkg::FSW_576;
            default: begin
                cif.freq_khz = 10'h000;
                cif.freq_ok  = 1'b0;
            end
        endcase
        // (R12) Bit clock ratio codes
        unique case (rto)
            4'h3: cif.ratio = acp_pkg::CLKS_32;
            4'h5: cif.ratio = acp_pkg::CLKS_64;
            4'h7: cif.ratio = acp_pkg::CLKS_128;
            4'h9: cif.ratio = acp_pkg::CLKS_256;
            4'hb: cif.ratio = acp_pkg::CLKS_512;
            default: begin
                cif.ratio    = 10'h000;
                cif.ratio_ok = 1'b0;
            end
        endcase
        // (R13) Sample rate codes
        unique case (fsm)
            4'h0: begin
                cif.rate_hz   = 17'h00000;
                cif.rate_auto = 1'b1;
            end
            4'h2: cif.rate_hz = acp_pkg::FS_8K;
            4'h4: cif.rate_hz = acp_pkg::FS_16K;
            4'h6: cif.rate_hz = acp_pkg::FS_32K;
            4'h8: cif.rate_hz = acp_pkg::FS_44K1;
            4'h9: cif.rate_hz = acp_pkg::FS_48K;
            4'ha: cif.rate_hz = acp_pkg::FS_88K2;
            4'hb: cif.rate_hz = acp_pkg::FS_96K;
            default: begin
                cif.rate_hz = 17'h00000;
                cif.rate_ok = 1'b0;
            end
        endcase
    end
endmodule

// [acp_host.sv]
`timescale 1ns/100ps
module acp_host (
    input  wire logic       clk_in,
    input  wire logic [7:0] rd_data_in,
    input  wire logic       rd_valid_in,
    output logic            load_out,
    output logic [7:0]      book_out,
    output logic [7:0]      page_out,
    output logic [7:0]      addr_out,
    output logic            valid_out,
    output logic            write_out,
    output logic [7:0]      wdata_out
);
    initial begin
        load_out = 1'b0;
        valid_out = 1'b0;
        write_out = 1'b0;
        book_out = 8'h00;
        page_out = 8'h00;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end

    // ----------------------------------------
    // Host side requests
    // ----------------------------------------
    task automatic set_ptr(input logic [7:0] b, p, a);
        valid_out = 1'b0;
        load_out = 1'b1;
        book_out = b;
        page_out = p;
        addr_out = a;
        @(posedge clk_in);
        #1;
    endtask

    // Read answer shows just after the taking edge
    task automatic acc(input logic w, input logic [7:0] d,
                       output logic [7:0] q, output logic v);
        load_out = 1'b0;
        valid_out = 1'b1;
        write_out = w;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        q = rd_data_in;
        v = rd_valid_in;
    endtask

    // Released wdata_out and addr_out stop showing their last value
    task automatic idle();
        load_out = 1'b0;
        valid_out = 1'b0;
        wdata_out = ~wdata_out;
        addr_out = ~addr_out;
        @(posedge clk_in);
        #1;
    endtask
endmodule

// [acp_ifs.sv]
`timescale 1ns/100ps
interface acp_ptr_if;
    logic       ce;
    logic       load;
    logic       step;
    logic       wrap_dis;
    logic [7:0] ld_book;
    logic [7:0] ld_page;
    logic [7:0] ld_addr;
    logic [7:0] book;
    logic [7:0] page;
    logic [7:0] addr;
    modport ctl (output ce, load, step, wrap_dis, ld_book, ld_page,
                 ld_addr, input book, page, addr);
    modport ptr (input ce, load, step, wrap_dis, ld_book, ld_page,
                 ld_addr, output book, page, addr);
endinterface

interface acp_cfg_if;
    logic [7:0]  stage;
    logic [7:0]  rate;
    logic [9:0]  freq_khz;
    logic        freq_ok;
    logic [9:0]  ratio;
    logic        ratio_ok;
    logic [16:0] rate_hz;
    logic        rate_auto;
    logic        rate_ok;
    modport bank (output stage, rate, input freq_khz, freq_ok, ratio,
                  ratio_ok, rate_hz, rate_auto, rate_ok);
    modport dec (input stage, rate, output freq_khz, freq_ok, ratio,
                 ratio_ok, rate_hz, rate_auto, rate_ok);
endinterface

// [acp_pkg.sv]
package acp_pkg;
    // Register offsets
    localparam logic [7:0] OFS_STAGE = 8'h02;
    localparam logic [7:0] OFS_RUN   = 8'h03;
    localparam logic [7:0] OFS_PAGE  = 8'h0f;
    localparam logic [7:0] OFS_RATE  = 8'h28;
    localparam logic [7:0] OFS_CLKM  = 8'h29;
    // Reset values
    localparam logic [7:0] RST_STAGE = 8'h00;
    localparam logic [7:0] RST_RUN   = 8'h10;
    localparam logic [7:0] RST_PAGE  = 8'h00;
    localparam logic [7:0] RST_RATE  = 8'h00;
    localparam logic [7:0] RST_CLKM  = 8'h00;
    // Field positions
    localparam int FSW_LSB   = 4;
    localparam int BRIDGE_BIT = 2;
    localparam int MOD_LSB   = 0;
    localparam int HOLD_BIT  = 4;
    localparam int MUTE_BIT  = 3;
    localparam int STATE_LSB = 0;
    localparam int WRAP_BIT  = 3;
    localparam int RATIO_LSB = 4;
    localparam int RATE_LSB  = 0;
    // Address walk
    localparam logic [7:0] PAGE_LAST  = 8'h7f;
    localparam logic [7:0] NEXT_START = 8'h08;
    localparam logic [7:0] SAME_START = 8'h00;
    localparam logic [7:0] BANK_BOOK  = 8'h00;
    localparam logic [7:0] BANK_PAGE  = 8'h00;
    // Switching rates, kHz
    localparam logic [9:0] FSW_768 = 10'h300;
    localparam logic [9:0] FSW_384 = 10'h180;
    localparam logic [9:0] FSW_480 = 10'h1e0;
    localparam logic [9:0] FSW_576 = 10'h240;
    // Bit clocks per frame
    localparam logic [9:0] CLKS_32  = 10'h020;
    localparam logic [9:0] CLKS_64  = 10'h040;
    localparam logic [9:0] CLKS_128 = 10'h080;
    localparam logic [9:0] CLKS_256 = 10'h100;
    localparam logic [9:0] CLKS_512 = 10'h200;
    // Sample rates, Hz
    localparam logic [16:0] FS_8K   = 17'h01f40;
    localparam logic [16:0] FS_16K  = 17'h03e80;
    localparam logic [16:0] FS_32K  = 17'h07d00;
    localparam logic [16:0] FS_44K1 = 17'h0ac44;
    localparam logic [16:0] FS_48K  = 17'h0bb80;
    localparam logic [16:0] FS_88K2 = 17'h15888;
    localparam logic [16:0] FS_96K  = 17'h17700;
    // Soft mute ramp
    localparam logic [7:0] GAIN_FULL = 8'hff;
    localparam logic [7:0] GAIN_ZERO = 8'h00;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RAMP_STEP_NS  = 160;
    localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ACP_MOD_BD, ACP_MOD_SSPWM, ACP_MOD_MIXED, ACP_MOD_UNDEF
    } acp_mod_t;
    typedef enum logic [1:0] {
        ACP_DEEP_SLEEP, ACP_SLEEP, ACP_HIZ, ACP_PLAY
    } acp_state_t;
    typedef enum logic [1:0] {
        ACP_RAMP_IDLE, ACP_RAMP_DOWN, ACP_RAMP_UP
    } acp_ramp_t;
endpackage

// [acp_regs.sv]
`timescale 1ns/100ps
// Summary of operation
// (R1) Switch code 000/001/011/100 gives 768/384/480/576 kHz.
// (R2) The host never writes switch codes 010, 101, 110 or 111.
// (R3) Bridge bit clear gives stereo bridge outputs, set gives mono.
// (R4) Modulation 00 two-level, 01 single-side, 10 mixed low idle.
// (R5) The host never writes modulation code 11.
// (R6) Processor hold resets set; clearing it lets the processor run.
// (R7) The host clears the hold only once input clocks have settled.
// (R8) Mute bit ramps the single volume gain smoothly down, and back up.
// (R9) State field 00 deep sleep, 01 sleep, 10 hi-z, 11 play.
// (R10) Wrap bit clear in non-zero book: page end goes to 8 of next.
// (R11) Wrap bit set: page end goes to location 0 of same page.
// (R12) Ratio 0011..1011 gives 32, 64, 128, 256, 512 clocks per frame.
// (R13) Rate field selects auto detection or a fixed sample rate.
// (R14) The host sets the rate field to the real rate or to auto.
// (R15) Fields read back as written and take reset values on reset.
module acp_regs #(
    parameter int RAMP_CYC = acp_pkg::RAMP_STEP_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        enable_in,
    input  wire logic        cmd_load_in,
    input  wire logic [7:0]  cmd_book_in,
    input  wire logic [7:0]  cmd_page_in,
    input  wire logic [7:0]  cmd_addr_in,
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_write_in,
    input  wire logic [7:0]  cmd_wdata_in,
    output logic      [7:0]  rd_data_out,
    output logic             rd_valid_out,
    output logic      [7:0]  ptr_page_out,
    output logic      [7:0]  ptr_addr_out,
    output logic      [9:0]  switch_freq_khz_out,
    output logic             switch_freq_ok_out,
    output logic             bridge_parallel_out,
    output acp_pkg::acp_mod_t modulation_out,
    output logic             processor_hold_out,
    output logic             soft_mute_out,
    output logic      [7:0]  volume_gain_out,
    output acp_pkg::acp_state_t power_state_out,
    output logic      [9:0]  bitclock_ratio_out,
    output logic             ratio_ok_out,
    output logic      [16:0] sample_rate_hz_out,
    output logic             rate_auto_out,
    output logic             rate_ok_out,
    output logic      [7:0]  clock_fault_mask_out
);
    // ------------------------------------------------------------
    // Address pointer and decoder
    // ------------------------------------------------------------
    acp_ptr_if pif ();
    acp_cfg_if cif ();

    acp_addr_ptr u_ptr (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .pif      (pif)
    );
    acp_field_decode u_dec (
        .cif (cif)
    );

    logic [7:0] stage;
    logic [7:0] run;
    logic [7:0] pgc;
    logic [7:0] rate;
    logic [7:0] clkm;
    logic [7:0] next_stage;
    logic [7:0] next_run;
    logic [7:0] next_pgc;
    logic [7:0] next_rate;
    logic [7:0] next_clkm;
    logic       acc;
    logic [2:0] sel;

    // Index 0 means no register at this place
    function automatic logic [2:0] bank_sel(input logic [7:0] bk,
                                            input logic [7:0] pg,
                                            input logic [7:0] ad);
        if (bk != acp_pkg::BANK_BOOK || pg != acp_pkg::BANK_PAGE)
            return 3'h0;
        unique case (ad)
            acp_pkg::OFS_STAGE: return 3'h1;
            acp_pkg::OFS_RUN:   return 3'h2;
            acp_pkg::OFS_PAGE:  return 3'h3;
            acp_pkg::OFS_RATE:  return 3'h4;
            acp_pkg::OFS_CLKM:  return 3'h5;
            default:            return 3'h0;
        endcase
    endfunction

    always_comb begin
        acc          = cmd_valid_in && !cmd_load_in;
        sel          = bank_sel(pif.book, pif.page, pif.addr);
        pif.ce       = enable_in;
        pif.load     = cmd_load_in;
        pif.step     = acc;
        pif.wrap_dis = pgc[acp_pkg::WRAP_BIT];
        pif.ld_book  = cmd_book_in;
        pif.ld_page  = cmd_page_in;
        pif.ld_addr  = cmd_addr_in;
        cif.stage    = stage;
        cif.rate     = rate;
    end

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    always_comb begin
        next_stage = stage;
        next_run   = run;
        next_pgc   = pgc;
        next_rate  = rate;
        next_clkm  = clkm;
        // (R15) Whole byte stored
        if (acc && cmd_write_in) begin
            unique case (sel)
                3'h1: next_stage = cmd_wdata_in;
                3'h2: next_run   = cmd_wdata_in;
                3'h3: next_pgc   = cmd_wdata_in;
                3'h4: next_rate  = cmd_wdata_in;
                3'h5: next_clkm  = cmd_wdata_in;
                default: ;
            endcase
        end
    end

    // (R15) Reset values
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            stage <= acp_pkg::RST_STAGE;
            run   <= acp_pkg::RST_RUN;
            pgc   <= acp_pkg::RST_PAGE;
            rate  <= acp_pkg::RST_RATE;
            clkm  <= acp_pkg::RST_CLKM;
        end else if (enable_in) begin
            stage <= next_stage;
            run   <= next_run;
            pgc   <= next_pgc;
            rate  <= next_rate;
            clkm  <= next_clkm;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] next_rd_data;
    logic       next_rd_valid;

    always_comb begin
        next_rd_valid = acc && !cmd_write_in;
        next_rd_data  = 8'h00;
        // (R15) Read back stored byte
        if (next_rd_valid) begin
            unique case (sel)
                3'h1: next_rd_data = stage;
                3'h2: next_rd_data = run;
                3'h3: next_rd_data = pgc;
                3'h4: next_rd_data = rate;
                3'h5: next_rd_data = clkm;
                default: next_rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_data_out  <= 8'h00;
            rd_valid_out <= 1'b0;
        end else if (enable_in) begin
            rd_data_out  <= next_rd_data;
            rd_valid_out <= next_rd_valid;
        end
    end

    // ------------------------------------------------------------
    // Soft mute ramp
    // ------------------------------------------------------------
    acp_pkg::acp_ramp_t ramp;
    acp_pkg::acp_ramp_t next_ramp;
    logic [15:0] tick;
    logic [15:0] next_tick;
    logic [7:0]  gain;
    logic [7:0]  next_gain;
    logic        muted;

    always_comb begin
        muted     = run[acp_pkg::MUTE_BIT];
        next_gain = gain;
        next_tick = tick;
        // (R8) Ramp direction follows mute
        if (muted && gain != acp_pkg::GAIN_ZERO)
            next_ramp = acp_pkg::ACP_RAMP_DOWN;
        else if (!muted && gain != acp_pkg::GAIN_FULL)
            next_ramp = acp_pkg::ACP_RAMP_UP;
        else
            next_ramp = acp_pkg::ACP_RAMP_IDLE;
        if (ramp == acp_pkg::ACP_RAMP_IDLE) begin
            next_tick = 16'h0000;
        end else if (tick != 16'(RAMP_CYC - 1)) begin
            next_tick = tick + 16'h0001;
        end else begin
            next_tick = 16'h0000;
            // (R8) One gain step per interval
            unique case (ramp)
                acp_pkg::ACP_RAMP_DOWN:
                    if (muted && gain != acp_pkg::GAIN_ZERO)
                        next_gain = gain - 8'h01;
                acp_pkg::ACP_RAMP_UP:
                    if (!muted && gain != acp_pkg::GAIN_FULL)
                        next_gain = gain + 8'h01;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ramp <= acp_pkg::ACP_RAMP_IDLE;
            tick <= 16'h0000;
            gain <= acp_pkg::GAIN_FULL;
        end else if (enable_in) begin
            ramp <= next_ramp;
            tick <= next_tick;
            gain <= next_gain;
        end
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ptr_page_out         <= 8'h00;
            ptr_addr_out         <= 8'h00;
            switch_freq_khz_out  <= acp_pkg::FSW_768;
            switch_freq_ok_out   <= 1'b1;
            bridge_parallel_out  <= 1'b0;
            modulation_out       <= acp_pkg::ACP_MOD_BD;
            processor_hold_out   <= 1'b1;
            soft_mute_out        <= 1'b0;
            volume_gain_out      <= acp_pkg::GAIN_FULL;
            power_state_out      <= acp_pkg::ACP_DEEP_SLEEP;
            bitclock_ratio_out   <= 10'h000;
            ratio_ok_out         <= 1'b0;
            sample_rate_hz_out   <= 17'h00000;
            rate_auto_out        <= 1'b1;
            rate_ok_out          <= 1'b1;
            clock_fault_mask_out <= acp_pkg::RST_CLKM;
        end else if (enable_in) begin
            ptr_page_out         <= pif.page;
            ptr_addr_out         <= pif.addr;
            // (R1) Switching rate out
            switch_freq_khz_out  <= cif.freq_khz;
            switch_freq_ok_out   <= cif.freq_ok;
            // (R3) Bridge topology
            bridge_parallel_out  <= stage[acp_pkg::BRIDGE_BIT];
            // (R4) Modulation scheme
            modulation_out       <=
                acp_pkg::acp_mod_t'(stage[acp_pkg::MOD_LSB +: 2]);
            // (R6) Processor hold
            processor_hold_out   <= run[acp_pkg::HOLD_BIT];
            soft_mute_out        <= muted;
            volume_gain_out      <= gain;
            // (R9) Power state request
            power_state_out      <=
                acp_pkg::acp_state_t'(run[acp_pkg::STATE_LSB +: 2]);
            // (R12) Bit clock ratio
            bitclock_ratio_out   <= cif.ratio;
            ratio_ok_out         <= cif.ratio_ok;
            // (R13) Sample rate mode
            sample_rate_hz_out   <= cif.rate_hz;
            rate_auto_out        <= cif.rate_auto;
            rate_ok_out          <= cif.rate_ok;
            clock_fault_mask_out <= clkm;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    chk_freq_code: assert property ( // (R1)
        enable_in && stage[6:4] == 3'h3 |=>
            switch_freq_khz_out == 10'h1e0 && switch_freq_ok_out)
        else $error("switch rate wrong for code 011");
    chk_bridge_topo: assert property ( // (R3)
        enable_in |=> bridge_parallel_out == $past(stage[2]))
        else $error("bridge topology does not follow bit");
    chk_mod_scheme: assert property ( // (R4)
        enable_in && stage[1:0] == 2'h1 |=>
            modulation_out == acp_pkg::ACP_MOD_SSPWM)
        else $error("modulation code 01 not single-side");
    chk_hold_write: assert property ( // (R6)
        enable_in && acc && cmd_write_in && sel == 3'h2 ##1 enable_in
            |=> processor_hold_out == $past(cmd_wdata_in[4], 2))
        else $error("processor hold does not follow write");
    chk_mute_ramp: assert property ( // (R8)
        muted && $past(muted) |-> gain <= $past(gain))
        else $error("gain rose while muted");
    chk_state_play: assert property ( // (R9)
        enable_in && run[1:0] == 2'h3 |=>
            power_state_out == acp_pkg::ACP_PLAY)
        else $error("state code 11 not play");
    chk_wrap_next: assert property ( // (R10)
        enable_in && !cmd_load_in && acc && pif.addr == 8'h7f &&
        pif.book != 8'h00 && !pgc[3] |=>
            pif.addr == 8'h08 && pif.page == $past(pif.page) + 8'h01)
        else $error("page end did not move to next page");
    chk_wrap_same: assert property ( // (R11)
        enable_in && !cmd_load_in && acc && pif.addr == 8'h7f &&
        pgc[3] |=> pif.addr == 8'h00 && $stable(pif.page))
        else $error("page end did not wrap in page");
    chk_ratio_code: assert property ( // (R12)
        enable_in && rate[7:4] == 4'hb |=> bitclock_ratio_out == 10'h200)
        else $error("ratio code 1011 not 512");
    chk_rate_code: assert property ( // (R13)
        enable_in && rate[3:0] == 4'h9 |=>
            sample_rate_hz_out == 17'h0bb80 && !rate_auto_out)
        else $error("rate code 1001 not 48 kHz");
    chk_read_back: assert property ( // (R15)
        enable_in && acc && !cmd_write_in && sel == 3'h1 |=>
            rd_valid_out && rd_data_out == $past(stage))
        else $error("stage read does not return stored byte");

    cov_mute_done: cover property (muted && gain == 8'h00);
    cov_page_adv: cover property (
        acc && pif.addr == 8'h7f && pif.book != 8'h00 && !pgc[3]);
    cov_play: cover property (power_state_out == acp_pkg::ACP_PLAY);
endmodule

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
    logic        clk_in, reset_in, enable_in, load, valid, write;
    logic [7:0]  book, page, addr, wdata, rd_data, ptr_page, ptr_addr;
    logic [7:0]  gain, mask, q, last;
    logic        rd_valid, freq_ok, bridge, hold, mute, ratio_ok, v;
    logic        rate_auto, rate_ok;
    logic [9:0]  freq, ratio;
    logic [16:0] rate_hz;
    acp_pkg::acp_mod_t   modulation;
    acp_pkg::acp_state_t state;
    int          mismatches, compares, cycles;

    acp_host host_u (.clk_in(clk_in), .rd_data_in(rd_data),
        .rd_valid_in(rd_valid), .load_out(load), .book_out(book),
        .page_out(page), .addr_out(addr), .valid_out(valid),
        .write_out(write), .wdata_out(wdata));

    acp_regs #(.RAMP_CYC(2)) dut_u (.clk_in(clk_in), .reset_in(reset_in),
        .enable_in(enable_in), .cmd_load_in(load), .cmd_book_in(book),
        .cmd_page_in(page), .cmd_addr_in(addr), .cmd_valid_in(valid),
        .cmd_write_in(write), .cmd_wdata_in(wdata), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .ptr_page_out(ptr_page),
        .ptr_addr_out(ptr_addr), .switch_freq_khz_out(freq),
        .switch_freq_ok_out(freq_ok), .bridge_parallel_out(bridge),
        .modulation_out(modulation), .processor_hold_out(hold),
        .soft_mute_out(mute), .volume_gain_out(gain),
        .power_state_out(state), .bitclock_ratio_out(ratio),
        .ratio_ok_out(ratio_ok), .sample_rate_hz_out(rate_hz),
        .rate_auto_out(rate_auto), .rate_ok_out(rate_ok),
        .clock_fault_mask_out(mask));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // ----------------------------------------
    // Checking and access helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [16:0] s, e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr_at(input logic [7:0] a, d);
        host_u.set_ptr(8'h00, 8'h00, a);
        host_u.acc(1'b1, d, q, v);
        host_u.idle();
    endtask

    task automatic rd_at(input logic [7:0] a, e);
        host_u.set_ptr(8'h00, 8'h00, a);
        host_u.acc(1'b0, 8'h00, q, v);
        chk("rd_valid", 17'(v), 17'h00001);
        chk("rd_data", 17'(q), 17'(e));
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    logic [7:0]  ofs[5] = '{8'h02, 8'h03, 8'h0f, 8'h28, 8'h29};
    logic [7:0]  rst[5] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
    logic [2:0]  fsw[4] = '{3'h0, 3'h1, 3'h3, 3'h4};
    logic [16:0] khz[4] = '{17'h300, 17'h180, 17'h1e0, 17'h240};
    logic [3:0]  rc[5] = '{4'h3, 4'h5, 4'h7, 4'h9, 4'hb};
    logic [16:0] clks[5] = '{17'h20, 17'h40, 17'h80, 17'h100, 17'h200};
    logic [3:0]  fc[8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb};
    logic [16:0] hz[8] = '{17'h0, 17'h1f40, 17'h3e80, 17'h7d00,
                           17'hac44, 17'hbb80, 17'h15888, 17'h17700};
    logic [1:0]  m;

    initial begin
        reset_in = 1'b1;
        enable_in = 1'b1;
        mismatches = 0;
        compares = 0;
        cycles = 0;
        repeat (8) @(posedge clk_in);
        #1 reset_in = 1'b0;
        for (int i = 0; i < 5; i++) rd_at(ofs[i], rst[i]);
        chk("hold", 17'(hold), 17'h1);
        chk("state", 17'(state), 17'h0);
        chk("gain", 17'(gain), 17'hff);
        chk("ratio_ok", 17'(ratio_ok), 17'h0);
        chk("auto", 17'(rate_auto), 17'h1);
        // Only defined switch and modulation codes
        for (int i = 0; i < 4; i++) begin
            m = 2'(i % 3);
            last = {1'b1, fsw[i], 1'b1, 1'(i), m};
            wr_at(8'h02, last);
            rd_at(8'h02, last);
            chk("freq", 17'(freq), khz[i]);
            chk("freq_ok", 17'(freq_ok), 17'h1);
            chk("bridge", 17'(bridge), 17'(i % 2));
            chk("mod", 17'(modulation), 17'(m));
        end
        // Clock enable low: nothing taken, outputs held
        enable_in = 1'b0;
        wr_at(8'h02, 8'h00);
        chk("frozen", 17'(freq), 17'h240);
        enable_in = 1'b1;
        rd_at(8'h02, last);
        // Hold cleared last, input clocks taken as settled
        for (int i = 0; i < 4; i++) begin
            wr_at(8'h03, {3'h5, 1'(i < 3), 2'h0, 2'(i)});
            chk("state", 17'(state), 17'(i));
            chk("hold", 17'(hold), 17'(i < 3));
        end
        wr_at(8'h03, 8'h0b);
        repeat (20) @(posedge clk_in);
        #1;
        chk("ramp_mid", 17'(gain < 8'hff && gain > 8'he0), 17'h1);
        repeat (600) @(posedge clk_in);
        #1;
        chk("gain_low", 17'(gain), 17'h0);
        chk("mute", 17'(mute), 17'h1);
        wr_at(8'h03, 8'h03);
        repeat (600) @(posedge clk_in);
        #1;
        chk("gain_high", 17'(gain), 17'hff);
        chk("unmute", 17'(mute), 17'h0);
        // Rate codes stay on real rates or auto
        for (int i = 0; i < 8; i++) begin
            wr_at(8'h28, {rc[i % 5], fc[i]});
            chk("ratio", 17'(ratio), clks[i % 5]);
            chk("ratio_ok", 17'(ratio_ok), 17'h1);
            chk("rate", rate_hz, hz[i]);
            chk("auto", 17'(rate_auto), 17'(i == 0));
            chk("rate_ok", 17'(rate_ok), 17'h1);
        end
        host_u.set_ptr(8'h00, 8'h00, 8'h28);
        host_u.acc(1'b1, 8'h5a, q, v);
        host_u.acc(1'b1, 8'ha5, q, v);
        host_u.idle();
        rd_at(8'h28, 8'h5a);
        rd_at(8'h29, 8'ha5);
        chk("mask", 17'(mask), 17'ha5);
        host_u.set_ptr(8'h01, 8'h00, 8'h02);
        host_u.acc(1'b1, 8'h77, q, v);
        host_u.idle();
        rd_at(8'h02, last);
        rd_at(8'h10, 8'h00);
        for (int w = 0; w < 2; w++) begin
            host_u.set_ptr(8'h01, 8'h02, 8'h7f);
            host_u.acc(1'b0, 8'h00, q, v);
            host_u.idle();
            chk("ptr_page", 17'(ptr_page), 17'(3 - w));
            chk("ptr_addr", 17'(ptr_addr), 17'(8 - 8 * w));
            wr_at(8'h0f, 8'h08);
        end
        print_verdict();
    end
endmodule
